// [verilog/eil_defs.svh]
`ifndef EIL_DEFS_SVH
`define EIL_DEFS_SVH
// divide ratio of the bus clock for the fetch serial clock
`define EIL_SCLK_DIV        256
`define EIL_SCLK_HALF       8'h7f
// microwire read command: start bit, opcode 10
`define EIL_CMD_READ        3'b110
`define EIL_CMD_BITS        3
`define EIL_ADDR_BITS       6
`define EIL_WORD_BITS       16
`define EIL_WORDS           4
// fixed identifiers presented when no memory is sensed
`define EIL_DEF_VENDOR      16'h0000
`define EIL_DEF_MODEL       16'h0000
`define EIL_DEF_SUBVENDOR   16'h0000
`define EIL_DEF_SUBMODEL    16'h0000
// control word bit positions, modem control infrared bit, channel and pin counts
`define EIL_CTL_CLK         0
`define EIL_CTL_SEL         1
`define EIL_CTL_WDATA       2
`define EIL_MCR_IR_BIT      6
`define EIL_CHANNELS        8
`define EIL_PINS            8
`endif

// [verilog/eil_pkg.sv]
package eil_pkg;
    typedef enum logic [5:0] {
        EIL_SENSE = 6'b00_0001,
        EIL_CMD   = 6'b00_0010,
        EIL_ADDR  = 6'b00_0100,
        EIL_DATA  = 6'b00_1000,
        EIL_GAP   = 6'b01_0000,
        EIL_DONE  = 6'b10_0000
    } eil_state_e;
    typedef logic [15:0] eil_word_t;
endpackage

// [verilog/eil_multi_pin.sv]
`timescale 1ns/10ps
`default_nettype none
`include "eil_defs.svh"
module eil_multi_pin #(
    parameter int PINS = `EIL_PINS
) (
    input  wire logic [PINS-1:0] multiPinSelect,
    input  wire logic [PINS-1:0] multiPinLevel,
    input  wire logic [PINS-1:0] multiPinInvert,
    input  wire logic [PINS-1:0] multiPinTristate,
    input  wire logic [PINS-1:0] multiPinIrqEnable,
    input  wire logic [PINS-1:0] multiPinIn,
    output logic      [PINS-1:0] multiPinOut,
    output logic      [PINS-1:0] multiPinOe_n,
    output logic      [PINS-1:0] multiPinState,
    output logic      [PINS-1:0] multiPinIrq
);
    // =====================================
    // per-pin configuration
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            // select high makes the pin an input; tristate floats an output
            assign multiPinOut[i]   = multiPinLevel[i];
            assign multiPinOe_n[i]  = multiPinSelect[i] | multiPinTristate[i];
            assign multiPinState[i] = multiPinIn[i] ^ multiPinInvert[i];
            assign multiPinIrq[i]   = multiPinSelect[i] & multiPinIrqEnable[i]
                                      & multiPinState[i];
        end
    endgenerate
endmodule
`default_nettype wire

// [verilog/eil_config_loader.sv]
`timescale 1ns/10ps
`default_nettype none
`include "eil_defs.svh"
// Functional notes
// - the fetch clocks the memory at the bus clock divided by 256.
// - outside the fetch software drives the memory clock level directly.
// - software raises and drops the memory select by a control bit.
// - software sets the write data and reads the read data line.
// - the select line level at power-up decides if a memory is present.
// - the infrared strap is sampled at power-up, bus reset and soft reset.
// - the sampled strap goes to modem control bit 6 of all eight channels.
// - each multipurpose pin is set by select, level, invert, tristate, irq bits.
// - memory contents serve only the four identifiers in configuration space.
// - the block works without a memory when auto configuration is unneeded.
module eil_config_loader #(
    parameter int CHANNELS = `EIL_CHANNELS,
    parameter int PINS     = `EIL_PINS
) (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                softReset,
    input  wire logic [2:0]          eepromControlReg,
    input  wire logic                eepromControlWrite,
    output logic      [3:0]          eepromControlRead,
    output logic                     eepromSerialClock,
    output logic                     eepromSelect,
    output logic                     eepromSelectOe_n,
    input  wire logic                eepromSelectIn,
    output logic                     eepromWriteData,
    input  wire logic                eepromReadData,
    input  wire logic                infraredStartStrap,
    output logic      [CHANNELS-1:0] modemControlIr,
    output logic                     fetchBusy,
    output logic                     eepromPresent,
    output eil_pkg::eil_word_t       vendorId,
    output eil_pkg::eil_word_t       modelId,
    output eil_pkg::eil_word_t       subVendorId,
    output eil_pkg::eil_word_t       subModelId,
    input  wire logic [PINS-1:0]     multiPinSelect,
    input  wire logic [PINS-1:0]     multiPinLevel,
    input  wire logic [PINS-1:0]     multiPinInvert,
    input  wire logic [PINS-1:0]     multiPinTristate,
    input  wire logic [PINS-1:0]     multiPinIrqEnable,
    input  wire logic [PINS-1:0]     multiPinIn,
    output logic      [PINS-1:0]     multiPinOut,
    output logic      [PINS-1:0]     multiPinOe_n,
    output logic      [PINS-1:0]     multiPinState,
    output logic      [PINS-1:0]     multiPinIrq
);
    import eil_pkg::*;

    // =====================================
    // serial clock divider
    logic [7:0] divCount;
    logic       sclkRise;
    logic       sclkFall;
    logic       fetchClk;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            divCount <= 8'h00;
        end else begin
            divCount <= divCount + 8'h01;
        end
    end
    // one full serial period spans 256 bus clocks
    assign sclkRise = (divCount == `EIL_SCLK_HALF);
    assign sclkFall = (divCount == 8'(`EIL_SCLK_DIV - 1));

    // =====================================
    // fetch sequencer
    eil_state_e state;
    logic [4:0] bitCount;
    logic [1:0] wordIndex;
    logic [15:0] shiftIn;
    logic        started;
    logic [2:0]  cmdBits;
    logic [5:0]  addrBits;

    assign cmdBits  = `EIL_CMD_READ;
    assign addrBits = {4'h0, wordIndex};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state     <= EIL_SENSE;
            bitCount  <= 5'h00;
            wordIndex <= 2'h0;
            shiftIn   <= 16'h0000;
            fetchClk  <= 1'b0;
            started   <= 1'b0;
            eepromPresent <= 1'b0;
        end else if (sclkFall) begin
            fetchClk <= 1'b0;
            unique case (state)
                EIL_SENSE: begin
                    // pull-up on select reads high only when a memory is fitted
                    eepromPresent <= eepromSelectIn;
                    state    <= eepromSelectIn ? EIL_CMD : EIL_DONE;
                    bitCount <= 5'h00;
                end
                EIL_CMD: begin
                    started <= 1'b1;
                    if (started && bitCount == 5'(`EIL_CMD_BITS - 1)) begin
                        state    <= EIL_ADDR;
                        bitCount <= 5'h00;
                    end else if (started) begin
                        bitCount <= bitCount + 5'h01;
                    end
                end
                EIL_ADDR: begin
                    if (bitCount == 5'(`EIL_ADDR_BITS - 1)) begin
                        state    <= EIL_DATA;
                        bitCount <= 5'h00;
                    end else begin
                        bitCount <= bitCount + 5'h01;
                    end
                end
                EIL_DATA: begin
                    if (bitCount == 5'(`EIL_WORD_BITS)) begin
                        state    <= EIL_GAP;
                        bitCount <= 5'h00;
                    end else begin
                        bitCount <= bitCount + 5'h01;
                    end
                end
                EIL_GAP: begin
                    started   <= 1'b0;
                    wordIndex <= wordIndex + 2'h1;
                    state     <= (wordIndex == 2'(`EIL_WORDS - 1)) ? EIL_DONE : EIL_CMD;
                end
                EIL_DONE: begin
                    state <= EIL_DONE;
                end
            endcase
        end else if (sclkRise && (state == EIL_CMD || state == EIL_ADDR
                                  || state == EIL_DATA) && started) begin
            fetchClk <= 1'b1;
            if (state == EIL_DATA && bitCount != 5'h00) begin
                shiftIn <= {shiftIn[14:0], eepromReadData};
            end
        end
    end

    // identifiers: defaults until a word lands, only ids taken from memory
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            vendorId    <= `EIL_DEF_VENDOR;
            modelId     <= `EIL_DEF_MODEL;
            subVendorId <= `EIL_DEF_SUBVENDOR;
            subModelId  <= `EIL_DEF_SUBMODEL;
        end else if (sclkFall && state == EIL_GAP) begin
            unique case (wordIndex)
                2'h0: vendorId    <= shiftIn;
                2'h1: modelId     <= shiftIn;
                2'h2: subVendorId <= shiftIn;
                2'h3: subModelId  <= shiftIn;
            endcase
        end
    end

    assign fetchBusy = (state != EIL_DONE);

    // =====================================
    // software bit-bang control
    logic [2:0] swControl;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            swControl <= 3'b000;
        end else if (eepromControlWrite && !fetchBusy) begin
            // writes during the fetch are dropped so they cannot corrupt it
            swControl <= eepromControlReg;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            eepromSerialClock <= 1'b0;
            eepromSelect      <= 1'b0;
            eepromWriteData   <= 1'b0;
        end else if (fetchBusy) begin
            eepromSerialClock <= fetchClk;
            eepromSelect      <= started;
            unique case (state)
                EIL_CMD:  eepromWriteData <= cmdBits[2'(`EIL_CMD_BITS - 1) - bitCount[1:0]];
                EIL_ADDR: eepromWriteData <= addrBits[3'(`EIL_ADDR_BITS - 1) - bitCount[2:0]];
                default:  eepromWriteData <= 1'b0;
            endcase
        end else begin
            eepromSerialClock <= swControl[`EIL_CTL_CLK];
            eepromSelect      <= swControl[`EIL_CTL_SEL];
            eepromWriteData   <= swControl[`EIL_CTL_WDATA];
        end
    end

    // select floats during sensing so the external pull-up sets the level
    assign eepromSelectOe_n  = (state == EIL_SENSE);
    assign eepromControlRead = {eepromReadData, swControl};

    // =====================================
    // infrared strap sampling
    logic strapPending;
    logic strapSampled;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            strapPending <= 1'b1;
            strapSampled <= 1'b0;
        end else if (strapPending || softReset) begin
            strapSampled <= infraredStartStrap;
            strapPending <= 1'b0;
        end
    end

    assign modemControlIr = {CHANNELS{strapSampled}};

    // =====================================
    // multipurpose pins
    eil_multi_pin #(
        .PINS (PINS)
    ) u_multi_pin (
        .multiPinSelect    (multiPinSelect),
        .multiPinLevel     (multiPinLevel),
        .multiPinInvert    (multiPinInvert),
        .multiPinTristate  (multiPinTristate),
        .multiPinIrqEnable (multiPinIrqEnable),
        .multiPinIn        (multiPinIn),
        .multiPinOut       (multiPinOut),
        .multiPinOe_n      (multiPinOe_n),
        .multiPinState     (multiPinState),
        .multiPinIrq       (multiPinIrq)
    );
endmodule
`default_nettype wire

// [bench/eil_config_loader_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
`include "eil_defs.svh"
module eil_config_loader_asserts #(
    parameter int CHANNELS = 8,
    parameter int PINS     = 8
) (
    input wire logic                ref_clk,
    input wire logic                resetn,
    input wire logic                softReset,
    input wire logic [2:0]          eepromControlReg,
    input wire logic                eepromControlWrite,
    input wire logic [3:0]          eepromControlRead,
    input wire logic                eepromSerialClock,
    input wire logic                eepromSelect,
    input wire logic                eepromSelectOe_n,
    input wire logic                eepromSelectIn,
    input wire logic                eepromWriteData,
    input wire logic                eepromReadData,
    input wire logic                infraredStartStrap,
    input wire logic [CHANNELS-1:0] modemControlIr,
    input wire logic                fetchBusy,
    input wire logic                eepromPresent,
    input wire eil_pkg::eil_word_t  vendorId,
    input wire logic [PINS-1:0]     multiPinSelect,
    input wire logic [PINS-1:0]     multiPinLevel,
    input wire logic [PINS-1:0]     multiPinInvert,
    input wire logic [PINS-1:0]     multiPinTristate,
    input wire logic [PINS-1:0]     multiPinIrqEnable,
    input wire logic [PINS-1:0]     multiPinIn,
    input wire logic [PINS-1:0]     multiPinOut,
    input wire logic [PINS-1:0]     multiPinOe_n,
    input wire logic [PINS-1:0]     multiPinState,
    input wire logic [PINS-1:0]     multiPinIrq
);
    // ========================================
    // helpers
    logic [7:0] hiCnt;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) hiCnt <= 8'h00;
        else hiCnt <= eepromSerialClock ? hiCnt + 8'h01 : 8'h00;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence ctlTaken;
        eepromControlWrite && !fetchBusy;
    endsequence
    // ========================================
    // checks
    sclk_high_time_a: assert property (
        $fell(eepromSerialClock) && fetchBusy |-> hiCnt == 8'(`EIL_SCLK_DIV / 2))
        else $error("fetch clock high time wrong");
    sel_frame_a: assert property (fetchBusy && eepromSerialClock |-> eepromSelect)
        else $error("fetch clock outside select");
    ctl_apply_a: assert property (ctlTaken |-> ##2
        {eepromWriteData, eepromSelect, eepromSerialClock} == $past(eepromControlReg, 2))
        else $error("control write not applied");
    ctl_readback_a: assert property (
        ctlTaken |=> eepromControlRead[2:0] == $past(eepromControlReg))
        else $error("control readback wrong");
    rd_pass_a: assert property (eepromControlRead[3] == eepromReadData)
        else $error("read data not visible");
    busy_refuse_a: assert property (fetchBusy |=> $stable(eepromControlRead[2:0]))
        else $error("write taken during fetch");
    sense_decide_a: assert property (
        $fell(eepromSelectOe_n) |-> eepromPresent == $past(eepromSelectIn))
        else $error("presence not taken from select line");
    default_ids_a: assert property (
        $fell(fetchBusy) && !eepromPresent |-> vendorId == `EIL_DEF_VENDOR)
        else $error("ids not default without memory");
    strap_copy_a: assert property (
        softReset |=> modemControlIr == {CHANNELS{$past(infraredStartStrap)}})
        else $error("strap not copied on soft reset");
    pin_drive_a: assert property (
        multiPinOut == multiPinLevel && multiPinOe_n == (multiPinSelect | multiPinTristate))
        else $error("pin drive wrong");
    pin_sense_a: assert property (multiPinState == (multiPinIn ^ multiPinInvert)
        && multiPinIrq == (multiPinSelect & multiPinIrqEnable & multiPinState))
        else $error("pin sense wrong");
endmodule
`default_nettype wire

// [bench/eil_eeprom_model.sv]
`timescale 1ns/10ps
`default_nettype none
module eil_eeprom_model (
    input  wire logic attached,
    input  wire logic sclk,
    input  wire logic sel,
    input  wire logic wdata,
    output logic      rdata
);
    int          n = 0;
    logic        selSeen = 1'b0;
    logic [5:0]  addr = 6'h00;
    logic [15:0] word = 16'h0000;
    initial rdata = 1'b0;
    // a change of select restarts the frame count; one process owns the count
    always @(posedge sclk or sel) begin
        if (sel !== selSeen) begin
            selSeen <= sel;
            n <= 0;
        end else if (sel) begin
            if (n >= 3 && n < 9) addr <= {addr[4:0], wdata};
            n <= n + 1;
        end
    end
    // a released output flips each clock so a stale bit never reads as good data
    always @(negedge sclk) begin
        if (!attached || !sel) rdata <= ~rdata;
        else if (n == 9) begin
            word <= 16'h5a30 | {10'h000, addr};
            rdata <= 1'b0;
        end
        else if (n >= 10 && n <= 25) rdata <= word[25-n];
        else rdata <= ~rdata;
    end
endmodule
`default_nettype wire

// [bench/eil_config_loader_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module eil_config_loader_tb;
    import eil_pkg::*;
    logic ref_clk, resetn, softReset, eepromControlWrite, eepromSelectIn, eepromReadData;
    logic infraredStartStrap, attached, eepromSerialClock, eepromSelect, eepromSelectOe_n;
    logic eepromWriteData, fetchBusy, eepromPresent;
    logic [2:0] eepromControlReg;
    logic [3:0] eepromControlRead;
    logic [7:0] modemControlIr, multiPinSelect, multiPinLevel, multiPinInvert, multiPinTristate;
    logic [7:0] multiPinIrqEnable, multiPinIn, multiPinOut, multiPinOe_n;
    logic [7:0] multiPinState, multiPinIrq;
    eil_word_t vendorId, modelId, subVendorId, subModelId;
    logic [63:0] expQ[$];
    int selQ[$];
    int n_errors = 0;
    int comparisons = 0;
    event chk;
    string nm[7] = '{"ids", "present", "strap copy", "control read", "serial outs",
                     "pins", "busy"};
    // pull-up on the select line only when a memory is fitted
    assign eepromSelectIn = eepromSelectOe_n ? attached : eepromSelect;
    eil_config_loader u_eil_config_loader (.*);
    eil_eeprom_model u_eil_eeprom_model (.attached(attached), .sclk(eepromSerialClock),
        .sel(eepromSelectIn), .wdata(eepromWriteData), .rdata(eepromReadData));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [63:0] seen(input int s);
        case (s)
            0: return {vendorId, modelId, subVendorId, subModelId};
            1: return {63'h0, eepromPresent};
            2: return {56'h0, modemControlIr};
            3: return {60'h0, eepromControlRead};
            4: return {61'h0, eepromWriteData, eepromSelect, eepromSerialClock};
            6: return {62'h0, fetchBusy, eepromSelectOe_n};
            default: return {32'h0, multiPinOut, multiPinOe_n, multiPinState, multiPinIrq};
        endcase
    endfunction
    always @(chk) begin
        while (expQ.size() > 0) begin
            comparisons++;
            if (seen(selQ[0]) !== expQ[0]) begin
                n_errors++;
                $display("ERROR %s expected %h seen %h", nm[selQ[0]], expQ[0], seen(selQ[0]));
            end
            void'(selQ.pop_front());
            void'(expQ.pop_front());
        end
    end
    task automatic note(input int s, input logic [63:0] e);
        expQ.push_back(e);
        selQ.push_back(s);
        ->chk;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic att, input logic strap);
        int i;
        resetn = 1'b0;
        attached = att;
        infraredStartStrap = strap;
        cyc(16);
        resetn = 1'b1;
        cyc(2);
        note(2, {56'h0, {8{strap}}});
        note(6, 64'h0000_0000_0000_0003);
        // writes thrown at the block during the fetch must be ignored
        for (i = 0; i < 40000 && fetchBusy !== 1'b0; i++) begin
            eepromControlWrite = 1'($urandom);
            eepromControlReg = 3'($urandom);
            cyc(1);
        end
        eepromControlWrite = 1'b0;
        if (i == 40000) begin
            n_errors++;
            $display("ERROR fetch end expected 0 seen %b", fetchBusy);
            give_verdict();
        end
        note(1, {63'h0, att});
        note(6, 64'h0000_0000_0000_0000);
        note(3, {60'h0, eepromReadData, 3'b000});
        note(0, att ? 64'h5a30_5a31_5a32_5a33 : 64'h0000_0000_0000_0000);
    endtask
    initial begin
        {softReset, eepromControlWrite, eepromControlReg} = 5'h00;
        {multiPinSelect, multiPinLevel, multiPinInvert} = 24'h00_0000;
        {multiPinTristate, multiPinIrqEnable, multiPinIn} = 24'h00_0000;
        void'($urandom(32'h1b1f));
        do_reset(1'b1, 1'b1);
        repeat (40) begin
            eepromControlWrite = 1'($urandom);
            eepromControlReg = 3'($urandom);
            cyc(1);
        end
        for (int v = 0; v < 8; v++) begin
            eepromControlWrite = 1'b1;
            eepromControlReg = 3'(v);
            cyc(1);
            eepromControlWrite = 1'b0;
            cyc(2);
            note(4, 64'(v));
            note(3, {60'h0, eepromReadData, 3'(v)});
        end
        infraredStartStrap = 1'b0;
        softReset = 1'b1;
        cyc(1);
        softReset = 1'b0;
        cyc(1);
        note(2, 64'h0000_0000_0000_0000);
        repeat (16) begin
            {multiPinSelect, multiPinLevel, multiPinInvert} = 24'($urandom);
            {multiPinTristate, multiPinIrqEnable, multiPinIn} = 24'($urandom);
            #1;
            note(5, {32'h0, multiPinLevel, multiPinSelect | multiPinTristate,
                multiPinIn ^ multiPinInvert,
                multiPinSelect & multiPinIrqEnable & (multiPinIn ^ multiPinInvert)});
            cyc(1);
        end
        do_reset(1'b0, 1'($urandom));
        cyc(2);
        give_verdict();
    end
endmodule
bind eil_config_loader eil_config_loader_asserts #(.CHANNELS(CHANNELS), .PINS(PINS))
    u_asserts (.*);
`default_nettype wire
